// >>> hw/core_regs_map.svh
// core_regs_map.svh: offsets, field positions and reset values of the core register set
// assumes inclusion by bare name from design files; definitions only
`ifndef CORE_REGS_MAP_SVH
`define CORE_REGS_MAP_SVH
// register-space address of the flags register (the only core register visible there)
`define FLAGS_REG_ADDR      8'hF7
// flags field positions
`define FLAG_GIE_BIT        0
`define FLAG_ZERO_BIT       1
`define FLAG_CARRY_BIT      2
`define FLAG_SUPER_BIT      3
`define FLAG_BANK_BIT       4
// mask of bits software may touch through or/and-with-flags
`define FLAGS_SW_MASK       8'h17
// reset values
`define FLAGS_RESET         8'h02
`define ACC_RESET           8'h00
`define INDEX_RESET         8'h00
`define SP_RESET            8'h00
`define PC_RESET            16'h0000
`endif

// >>> hw/core_regs_pkg.sv
// core_regs_pkg.sv: types shared by the core register set and its decoder
// assumes nothing beyond a SystemVerilog compiler
package core_regs_pkg;
   // result destination chosen by the decoder
   typedef enum logic [2:0] {
      DST_NONE,
      DST_ACC,
      DST_INDEX,
      DST_SP,
      DST_FLAGS
   } dest_sel_t;
   // flag operation: software or/and, or alu update
   typedef enum logic [1:0] {
      FOP_NONE,
      FOP_OR,
      FOP_AND,
      FOP_ALU
   } flag_op_t;
   // program counter operation
   typedef enum logic [1:0] {
      PC_HOLD,
      PC_INC,
      PC_LOAD
   } pc_op_t;
endpackage : core_regs_pkg

// >>> hw/core_register_set.sv
// core_register_set.sv: architectural register set of the 8-bit core
// assumes the decoder and alu drive the control ports on the core clock
//
// Behaviour
// - core registers change only through instructions
// - program counter is sixteen bits wide
// - pc high/low bytes viewable, reset zero
// - accumulator takes source-mode results, resets zero
// - index supplies base for indexed addresses, OFFSET_IN the offset
// - stack pointer holds top-of-stack, resets zero
// - stack ops, swap and add change pointer
// - flags: gie0, zero1, carry2, super3
// - global interrupt enable gates all interrupts
// - super bit shows mode, user cannot change
// - carry and zero reflect last result
// - alu instructions update flags per instruction
// - software changes flags via or/and only
// - flags readable only at address F7
// - fetch starts at address zero after reset
`include "core_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module core_register_set
   import core_regs_pkg::*;
#(
   parameter int PC_WIDTH = 16,          // program counter width
   parameter int DATA_WIDTH = 8          // data path width
) (
   // clock and reset
   input  wire logic                  CLK_IN,
   input  wire logic                  RST_N_IN,
   // result write from the instruction decoder
   input  wire dest_sel_t             DEST_SEL_IN,
   input  wire logic [DATA_WIDTH-1:0] RESULT_IN,
   // flag update
   input  wire flag_op_t              FLAG_OP_IN,
   input  wire logic [DATA_WIDTH-1:0] FLAG_OPERAND_IN,
   input  wire logic                  ALU_CARRY_IN,
   input  wire logic                  ALU_ZERO_IN,
   input  wire logic                  SUPER_ENTER_IN,
   input  wire logic                  SUPER_EXIT_IN,
   // stack pointer step from stack instructions
   input  wire logic                  SP_INC_IN,
   input  wire logic                  SP_DEC_IN,
   // program counter control
   input  wire pc_op_t                PC_OP_IN,
   input  wire logic [PC_WIDTH-1:0]   PC_LOAD_IN,
   // indexed address formation
   input  wire logic [DATA_WIDTH-1:0] OFFSET_IN,
   // register-space read port
   input  wire logic [7:0]            REG_ADDR_IN,
   // interrupt gating
   input  wire logic                  IRQ_PENDING_IN,
   // register views
   output logic [DATA_WIDTH-1:0]      ACC_OUT,
   output logic [DATA_WIDTH-1:0]      INDEX_OUT,
   output logic [DATA_WIDTH-1:0]      SP_OUT,
   output logic [DATA_WIDTH-1:0]      FLAGS_OUT,
   output logic [DATA_WIDTH-1:0]      PC_HIGH_OUT,
   output logic [DATA_WIDTH-1:0]      PC_LOW_OUT,
   output logic [PC_WIDTH-1:0]        FETCH_ADDR_OUT,
   // derived outputs
   output logic [DATA_WIDTH-1:0]      INDEXED_ADDR_OUT,
   output logic                       BANK_SEL_OUT,
   output logic                       IRQ_TAKE_OUT,
   output logic                       REG_HIT_OUT,
   output logic [DATA_WIDTH-1:0]      REG_RDATA_OUT
);

   logic [DATA_WIDTH-1:0] acc_r;          // accumulator
   logic [DATA_WIDTH-1:0] index_r;        // index register
   logic [DATA_WIDTH-1:0] sp_r;           // stack pointer
   logic [DATA_WIDTH-1:0] flags_r;        // flags register
   logic [DATA_WIDTH-1:0] flags_nxt;      // next flags value
   logic [PC_WIDTH-1:0]   program_counter_r; // program counter

   // accumulator: loaded only by a decoded result, never by a bus write
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         acc_r <= `ACC_RESET;
      end else if (DEST_SEL_IN == DST_ACC) begin
         acc_r <= RESULT_IN;
      end
   end

   // index register
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         index_r <= `INDEX_RESET;
      end else if (DEST_SEL_IN == DST_INDEX) begin
         index_r <= RESULT_IN;
      end
   end

   // stack pointer: a direct result (swap, add) beats a push/pop step
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         sp_r <= `SP_RESET;
      end else if (DEST_SEL_IN == DST_SP) begin
         sp_r <= RESULT_IN;
      end else if (SP_INC_IN && !SP_DEC_IN) begin
         sp_r <= sp_r + 8'h01;
      end else if (SP_DEC_IN && !SP_INC_IN) begin
         sp_r <= sp_r - 8'h01;
      end
   end

   // next flags: or/and touch only writable bits, super stays hardware-owned
   always_comb begin
      flags_nxt = flags_r;
      unique case (FLAG_OP_IN)
         FOP_OR: begin
            flags_nxt = flags_r | (FLAG_OPERAND_IN & `FLAGS_SW_MASK);
         end
         FOP_AND: begin
            flags_nxt = flags_r & (FLAG_OPERAND_IN | ~`FLAGS_SW_MASK);
         end
         FOP_ALU: begin
            flags_nxt[`FLAG_CARRY_BIT] = ALU_CARRY_IN;
            flags_nxt[`FLAG_ZERO_BIT]  = ALU_ZERO_IN;
         end
         FOP_NONE: begin
            flags_nxt = flags_r;
         end
      endcase
      // supervisor entry wins over exit; only hardware events move it
      if (SUPER_ENTER_IN) begin
         flags_nxt[`FLAG_SUPER_BIT] = 1'b1;
      end else if (SUPER_EXIT_IN) begin
         flags_nxt[`FLAG_SUPER_BIT] = 1'b0;
      end
      flags_nxt[7:5] = 3'h0;                                           // reserved read zero
   end

   // flags register
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         flags_r <= `FLAGS_RESET;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // program counter: reset puts the first fetch at zero
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         program_counter_r <= `PC_RESET;
      end else begin
         unique case (PC_OP_IN)
            PC_INC:  program_counter_r <= program_counter_r + 16'h0001;
            PC_LOAD: program_counter_r <= PC_LOAD_IN;
            default: program_counter_r <= program_counter_r;            // hold or unused code
         endcase
      end
   end

   // register views straight from flip-flops
   assign ACC_OUT        = acc_r;
   assign INDEX_OUT      = index_r;
   assign SP_OUT         = sp_r;
   assign FLAGS_OUT      = flags_r;
   assign PC_HIGH_OUT    = program_counter_r[15:8];
   assign PC_LOW_OUT     = program_counter_r[7:0];
   assign FETCH_ADDR_OUT = program_counter_r;

   // indexed address wraps within the 8-bit space
   assign INDEXED_ADDR_OUT = index_r + OFFSET_IN;
   assign BANK_SEL_OUT     = flags_r[`FLAG_BANK_BIT];
   assign IRQ_TAKE_OUT     = IRQ_PENDING_IN & flags_r[`FLAG_GIE_BIT];

   // only the flags answer in register space; other core registers stay hidden
   assign REG_HIT_OUT   = (REG_ADDR_IN == `FLAGS_REG_ADDR);
   assign REG_RDATA_OUT = REG_HIT_OUT ? flags_r : 8'h00;

endmodule : core_register_set
`default_nettype wire

// >>> verif/core_regs_checker.sv
// checker: port assertions for the core register set
// assumes a bind onto core_register_set and a single clock
`timescale 1ns/1ps
`default_nettype none
module core_regs_checker
   import core_regs_pkg::*;
(
   // watched ports, same names as the design
   input wire logic       CLK_IN, RST_N_IN, SP_INC_IN, SP_DEC_IN, ALU_CARRY_IN, ALU_ZERO_IN,
   input wire logic       SUPER_ENTER_IN, SUPER_EXIT_IN, IRQ_PENDING_IN, IRQ_TAKE_OUT, BANK_SEL_OUT,
   input wire dest_sel_t  DEST_SEL_IN,
   input wire flag_op_t   FLAG_OP_IN,
   input wire pc_op_t     PC_OP_IN,
   input wire logic [7:0] RESULT_IN, FLAG_OPERAND_IN, ACC_OUT, SP_OUT, FLAGS_OUT,
   input wire logic [15:0] FETCH_ADDR_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // or-request alone: a mode change in the same cycle would move bit 3
   sequence s_or_req;
      FLAG_OP_IN == FOP_OR && !SUPER_ENTER_IN && !SUPER_EXIT_IN;
   endsequence
   a_acc_load: assert property (DEST_SEL_IN == DST_ACC |=> ACC_OUT == $past(RESULT_IN))
      else $error("acc missed result");
   a_pc_step: assert property (PC_OP_IN == PC_INC |=> FETCH_ADDR_OUT == $past(FETCH_ADDR_OUT) + 16'h0001)
      else $error("pc step wrong");
   a_sp_push: assert property (SP_INC_IN && !SP_DEC_IN && DEST_SEL_IN != DST_SP |=> SP_OUT == $past(SP_OUT) + 8'h01)
      else $error("sp step wrong");
   a_irq_gate: assert property (IRQ_TAKE_OUT == (IRQ_PENDING_IN && FLAGS_OUT[0]))
      else $error("irq gate wrong");
   a_super_hold: assert property (!SUPER_ENTER_IN && !SUPER_EXIT_IN |=> $stable(FLAGS_OUT[3]))
      else $error("super bit moved");
   a_alu_carry: assert property (FLAG_OP_IN == FOP_ALU |=> FLAGS_OUT[2] == $past(ALU_CARRY_IN))
      else $error("carry flag wrong");
   a_or_flags: assert property (s_or_req |=> FLAGS_OUT == ($past(FLAGS_OUT) | ($past(FLAG_OPERAND_IN) & 8'h17)))
      else $error("or on flags wrong");
   a_bank_view: assert property (BANK_SEL_OUT == FLAGS_OUT[4])
      else $error("bank select wrong");
endmodule : core_regs_checker
bind core_register_set core_regs_checker i_chk (.*);
`default_nettype wire

// >>> verif/core_alu_model.sv
// model: adder standing in for the core's alu
// assumes operands held by the bench
`timescale 1ns/1ps
`default_nettype none
module core_alu_model (
   input  wire logic [7:0] a_in,      // first operand
   input  wire logic [7:0] b_in,      // second operand
   output logic [7:0]      sum_out,   // result to the register set
   output logic            carry_out, // carry of the add
   output logic            zero_out   // result was zero
);
   // nine-bit add keeps the carry without a second adder
   assign {carry_out, sum_out} = {1'b0, a_in} + {1'b0, b_in};
   assign zero_out = (sum_out == 8'h00);
endmodule : core_alu_model
`default_nettype wire

// >>> verif/tb_top.sv
// bench: drives the register set on falling edges, checks from a queue
// assumes the alu model feeds result and status
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import core_regs_pkg::*;
   logic clk, rst_n, sinc, sdec, sen, sex, irq, cy, zf, bank, take, hit;
   logic [7:0] a, b, fm, offs, addr, sum, acc, idx, sp, flg, pch, pcl, ia, rd;
   logic [15:0] pcld, fa;
   dest_sel_t dst;
   flag_op_t fop;
   pc_op_t pcop;
   logic [19:0] notes[$], n; // expected {slot, value}
   int fails = 0, total_checks = 0, r, i;
   // slots: 0 acc 1 x 2 sp 3 flags 4 fetch 5 pc 6 indexed 7 bank 8 rdata 9 hit 10 irq
   wire logic [175:0] obs = {16'(take), 16'(hit), 16'(rd), 16'(bank), 16'(ia), pch, pcl, fa,
      16'(flg), 16'(sp), 16'(idx), 16'(acc)};
   core_alu_model i_alu (.a_in(a), .b_in(b), .sum_out(sum), .carry_out(cy), .zero_out(zf));
   core_register_set i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .DEST_SEL_IN(dst), .RESULT_IN(sum),
      .FLAG_OP_IN(fop), .FLAG_OPERAND_IN(fm), .ALU_CARRY_IN(cy), .ALU_ZERO_IN(zf), .SUPER_ENTER_IN(sen),
      .SUPER_EXIT_IN(sex), .SP_INC_IN(sinc), .SP_DEC_IN(sdec), .PC_OP_IN(pcop), .PC_LOAD_IN(pcld),
      .OFFSET_IN(offs), .REG_ADDR_IN(addr), .IRQ_PENDING_IN(irq), .ACC_OUT(acc), .INDEX_OUT(idx),
      .SP_OUT(sp), .FLAGS_OUT(flg), .PC_HIGH_OUT(pch), .PC_LOW_OUT(pcl), .FETCH_ADDR_OUT(fa),
      .INDEXED_ADDR_OUT(ia), .BANK_SEL_OUT(bank), .IRQ_TAKE_OUT(take), .REG_HIT_OUT(hit), .REG_RDATA_OUT(rd));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   task automatic check(logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic want(logic [3:0] k, logic [15:0] e);
      notes.push_back({k, e});
   endtask : want
   // all controls idle, so each step asks for one thing
   task automatic idle;
      {sinc, sdec, sen, sex, irq} = '0;
      dst = DST_NONE;
      fop = FOP_NONE;
      pcop = PC_HOLD;
   endtask : idle
   task automatic nx;
      @(negedge clk);
      idle;
   endtask : nx
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : results
   // outputs settle 1 ns after the edge; drain every note made for it
   always @(posedge clk) begin
      #1;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         check(obs[n[19:16]*16 +: 16], n[15:0]);
      end
   end
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      results;
   end
   initial begin
      void'($urandom(32'h8a12_7aeb));
      {rst_n, a, b, fm, offs, addr, pcld} = '0;
      idle;
      repeat (7) @(posedge clk);
      nx; want(0, 0); want(1, 0); want(2, 0); want(5, 0);
      want(3, 16'h0002);
      nx; rst_n = 1; want(4, 0);
      r = $urandom;
      nx; a = r[7:0]; dst = DST_ACC; want(0, r[7:0]);
      nx; a = r[15:8]; offs = r[23:16]; dst = DST_INDEX; want(1, r[15:8]);
      want(6, 16'(8'(r[15:8] + r[23:16])));
      nx; a = 8'hff; b = 8'h01; fop = FOP_ALU; want(3, 16'h0006);
      nx; a = 8'h10; fop = FOP_ALU; want(3, 16'h0000);
      nx; fm = 8'hff; fop = FOP_OR; want(3, 16'h0017); want(7, 1);
      nx; irq = 1; addr = 8'hf7; want(10, 1); want(9, 1); want(8, 16'h0017);
      nx; irq = 1; addr = 8'hf6; fm = 8'h00; fop = FOP_AND; want(10, 0); want(9, 0); want(8, 0);
      nx; sen = 1; want(3, 16'h0008);
      nx; fop = FOP_AND; want(3, 16'h0008);
      nx; sex = 1; want(3, 0);
      nx; a = 8'hff; b = 8'h00; dst = DST_FLAGS; want(3, 0);
      nx; sinc = 1; want(2, 1);
      nx; sdec = 1; want(2, 0);
      nx; sinc = 1; a = 8'h40; b = 0; dst = DST_SP; want(2, 16'h0040);
      nx; sinc = 1; sdec = 1; want(2, 16'h0040);
      for (i = 0; i < 2; i++) begin
         nx; pcld = i ? 16'hffff : r[31:16]; pcop = PC_LOAD; want(4, pcld); want(5, pcld);
         nx; pcop = PC_INC; want(4, pcld + 16'h0001);
      end
      nx; nx;
      results;
   end
endmodule : tb_top
`default_nettype wire
